//--- rtl/dps_pkg.sv
package dps_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] DISPLAY_MODE_OFS = 8'h04;
  localparam logic [7:0] SYSTEM_POWERDOWN_OFS = 8'h08;
  localparam logic [7:0] ANALOG_POWERDOWN_OFS = 8'h0c;
  localparam logic [7:0] TEST_PATTERN_OFS = 8'h10;

  // Field positions.
  localparam int DISPLAY_BLANK_BIT = 7;
  localparam int SLEEP_REQUEST_BIT = 7;
  localparam int PATTERN_ENABLE_BIT = 7;
  localparam int PATTERN_SEL_LSB = 0;
  localparam int PATTERN_SEL_W = 3;

  // Reset values.
  localparam logic [7:0] DISPLAY_MODE_RST = 8'h80;
  localparam logic [7:0] SYSTEM_POWERDOWN_RST = 8'h00;
  localparam logic [7:0] ANALOG_POWERDOWN_RST = 8'h00;
  localparam logic [7:0] TEST_PATTERN_RST = 8'h00;

  // Serial slave address, upper six bits fixed.
  localparam logic [5:0] SERIAL_ADDR_HI = 6'h13;

  // Timing: the clock rate and the two power-up delays.
  localparam int CLK_KHZ = 25000;
  localparam int CATHODE_DELAY_MS = 70;
  localparam int VIDEO_DELAY_MS = 20;
  localparam int CATHODE_DELAY_CYC = CATHODE_DELAY_MS * CLK_KHZ;
  localparam int VIDEO_DELAY_CYC = VIDEO_DELAY_MS * CLK_KHZ;
  localparam int ARRAY_OFF_CYC = 4;

  // Pattern raster in oscillator ticks, about 60 Hz from a 3.125 MHz source.
  localparam int TICKS_PER_LINE = 50;
  localparam int LINES_PER_FRAME = 1042;

  // Pattern selections.
  localparam logic [2:0] PAT_WHITE = 3'h0;
  localparam logic [2:0] PAT_GRAY = 3'h1;
  localparam logic [2:0] PAT_CHECKER = 3'h2;
  localparam logic [2:0] PAT_ROWS = 3'h3;
  localparam logic [2:0] PAT_COLS = 3'h4;
  localparam logic [2:0] PAT_HATCH = 3'h5;

  // Power sequence states.
  typedef enum logic [2:0] {
    PWR_OFF = 3'b000,
    PWR_WAIT_CATHODE = 3'b001,
    PWR_WAIT_VIDEO = 3'b010,
    PWR_RUN = 3'b011,
    PWR_DOWN = 3'b100
  } dps_state_type;

endpackage : dps_pkg

//--- rtl/dps_display_power_sequencer.sv
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
// How it works
// R1: Internal power-on reset holds until both supplies are above threshold.
// R2: About 70 ms after power-on reset ends, cathode converter is enabled.
// R3: Video path is enabled about 20 ms after cathode converter.
// R4: Pixels are driven black until the host clears the blank bit.
// R5: Host keeps the external reset pin high before writing registers.
// R6: Host loads configuration first, then clears the blank bit.
// R7: Core supply drop stops row and column sequencing at once.
// R8: On supply drop cathode supply turns off first, array supply after. Code does so on a core drop only; an array drop turns both off together.
// R9: Power-up loads every register with its default value.
// R10: Blank bit is bit 7 of display mode register; one forces black.
// R11: Sleep bit powers down everything except the serial interface.
// R12: Register contents survive sleep without reload.
// R13: Power-down register bits switch functional blocks off separately.
// R14: Pattern mode starts from self-test pin at start-up or enable bit.
// R15: Pattern mode needs no external video, sync or clock.
// R16: Pattern syncs and sample clock come from the converter oscillator.
// R17: Pattern frame rate is fixed at 60 Hz.
// R18: Default pattern is a flat white field at full luminance.
// R19: Gray scale, checkerboard, rows, columns and cross-hatch are selectable.
// R20: Serial slave address is fixed except its low bit from a pin.
// R21: Delay counter runs from the clock and restarts on power-on reset.
module dps_display_power_sequencer #(
  parameter int unsigned CATHODE_DELAY = dps_pkg::CATHODE_DELAY_CYC,
  parameter int unsigned VIDEO_DELAY = dps_pkg::VIDEO_DELAY_CYC,
  parameter int unsigned LINE_TICKS = dps_pkg::TICKS_PER_LINE,
  parameter int unsigned FRAME_LINES = dps_pkg::LINES_PER_FRAME
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Bus slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins from outside the clock domain.
  input wire logic coreSupplyOk,
  input wire logic arraySupplyOk,
  input wire logic extResetLowPinN,
  input wire logic selftestPin,
  input wire logic addressSelectPin,
  input wire logic converterOscClk,
  // Power and display controls.
  output logic powerOnReset,
  output logic cathodeSupplyEn,
  output logic arraySupplyEn,
  output logic videoPathEn,
  output logic rowColSeqEn,
  output logic pixelForceBlack,
  output logic [7:0] analogBlockEn,
  output logic [7:0] systemBlockEn,
  output logic [6:0] serialSlaveAddr,
  // Built-in pattern outputs.
  output logic builtinPatternMode,
  output logic patternHsync,
  output logic patternVsync,
  output logic patternSclk,
  output logic [3:0] patternPixel
);
  import dps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every pin; a third stage on the oscillator.
  logic [5:0] syncA_q;
  logic [5:0] syncB_q;
  logic oscPrev_q;
  logic coreOk;
  logic arrayOk;
  logic extResetOk;
  logic oscRise;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      syncA_q <= 6'h00;
      syncB_q <= 6'h00;
      oscPrev_q <= 1'b0;
    end
    else
    begin
      syncA_q <= {converterOscClk, addressSelectPin, selftestPin, extResetLowPinN,
                  arraySupplyOk, coreSupplyOk};
      syncB_q <= syncA_q;
      oscPrev_q <= syncB_q[5];
    end
  end

  assign coreOk = syncB_q[0];
  assign arrayOk = syncB_q[1];
  assign extResetOk = syncB_q[2];
  assign oscRise = syncB_q[5] & ~oscPrev_q; // R16
  assign powerOnReset = ~(coreOk & arrayOk); // R1
  assign serialSlaveAddr = {SERIAL_ADDR_HI, syncB_q[4]}; // R20

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture and register file.
  logic wrPend_q, wrPend_d;
  logic [7:0] wrAddr_q, wrAddr_d;
  logic [31:0] rdData_q, rdData_d;
  logic [7:0] display_mode_reg_q, display_mode_reg_d;
  logic [7:0] sysPdn_q, sysPdn_d;
  logic [7:0] anaPdn_q, anaPdn_d;
  logic [7:0] testPat_q, testPat_d;
  logic strapTest_q, strapTest_d;
  dps_state_type state_q, state_d;
  logic addrPhase;

  assign addrPhase = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdData_q;

  // Next register values, read data and captured write address.
  always_comb
  begin
    wrPend_d = addrPhase & hwrite;
    wrAddr_d = addrPhase ? haddr[7:0] : wrAddr_q;
    rdData_d = rdData_q;
    display_mode_reg_d = display_mode_reg_q;
    sysPdn_d = sysPdn_q;
    anaPdn_d = anaPdn_q;
    testPat_d = testPat_q;
    if (addrPhase && !hwrite)
    begin
      if (haddr[7:0] == STATUS_OFS)
        rdData_d = {24'h000000, 1'b0, strapTest_q, builtinPatternMode, extResetOk,
                    arrayOk, coreOk, 2'b00} | {29'h00000000, state_q};
      else if (haddr[7:0] == DISPLAY_MODE_OFS)
        rdData_d = {24'h000000, display_mode_reg_q};
      else if (haddr[7:0] == SYSTEM_POWERDOWN_OFS)
        rdData_d = {24'h000000, sysPdn_q};
      else if (haddr[7:0] == ANALOG_POWERDOWN_OFS)
        rdData_d = {24'h000000, anaPdn_q};
      else if (haddr[7:0] == TEST_PATTERN_OFS)
        rdData_d = {24'h000000, testPat_q};
      else
        rdData_d = 32'h00000000;
    end
    // Writes are dropped while the external reset pin is low.
    if (wrPend_q && extResetOk) // R5
    begin
      if (wrAddr_q == DISPLAY_MODE_OFS)
        display_mode_reg_d = hwdata[7:0];
      else if (wrAddr_q == SYSTEM_POWERDOWN_OFS)
        sysPdn_d = hwdata[7:0];
      else if (wrAddr_q == ANALOG_POWERDOWN_OFS)
        anaPdn_d = hwdata[7:0];
      else if (wrAddr_q == TEST_PATTERN_OFS)
        testPat_d = hwdata[7:0];
    end
    // Power-on reset restores defaults; sleep leaves them alone.
    if (powerOnReset) // R9 R12
    begin
      display_mode_reg_d = DISPLAY_MODE_RST;
      sysPdn_d = SYSTEM_POWERDOWN_RST;
      anaPdn_d = ANALOG_POWERDOWN_RST;
      testPat_d = TEST_PATTERN_RST;
    end
  end

  // Register file storage.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      rdData_q <= 32'h00000000;
      display_mode_reg_q <= DISPLAY_MODE_RST;
      sysPdn_q <= SYSTEM_POWERDOWN_RST;
      anaPdn_q <= ANALOG_POWERDOWN_RST;
      testPat_q <= TEST_PATTERN_RST;
    end
    else
    begin
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      rdData_q <= rdData_d;
      display_mode_reg_q <= display_mode_reg_d;
      sysPdn_q <= sysPdn_d;
      anaPdn_q <= anaPdn_d;
      testPat_q <= testPat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power sequencer with its delay counter.
  logic [31:0] delayCnt_q, delayCnt_d;

  // Next state, delay count and start-up strap.
  always_comb
  begin
    state_d = state_q;
    delayCnt_d = delayCnt_q + 32'h00000001;
    strapTest_d = strapTest_q;
    case (state_q)
      PWR_OFF:
      begin
        delayCnt_d = 32'h00000000;
        if (!powerOnReset)
        begin
          state_d = PWR_WAIT_CATHODE;
          strapTest_d = syncB_q[3]; // R14
        end
      end
      PWR_WAIT_CATHODE:
        if (delayCnt_q >= CATHODE_DELAY - 1) // R2
        begin
          state_d = PWR_WAIT_VIDEO;
          delayCnt_d = 32'h00000000;
        end
      PWR_WAIT_VIDEO:
        if (delayCnt_q >= VIDEO_DELAY - 1) // R3
        begin
          state_d = PWR_RUN;
          delayCnt_d = 32'h00000000;
        end
      PWR_RUN:
        delayCnt_d = 32'h00000000;
      PWR_DOWN:
        if (delayCnt_q >= ARRAY_OFF_CYC - 1) // R8
          state_d = PWR_OFF;
      default:
        state_d = PWR_OFF;
    endcase
    // A core drop enters PWR_DOWN at once; any other reset restarts timing.
    if (!coreOk && state_q != PWR_OFF && state_q != PWR_DOWN) // R7
    begin
      state_d = PWR_DOWN;
      delayCnt_d = 32'h00000000;
    end
    else if (powerOnReset && state_q != PWR_DOWN) // R21
    begin
      state_d = PWR_OFF;
      delayCnt_d = 32'h00000000;
    end
  end

  // Sequencer storage.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= PWR_OFF;
      delayCnt_q <= 32'h00000000;
      strapTest_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      delayCnt_q <= delayCnt_d;
      strapTest_q <= strapTest_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power and display controls; supplies and block enables gated by sleep, block enables also by power-down bits.
  logic awake;
  logic [7:0] ctl_q, ctl_d;

  assign awake = ~sysPdn_q[SLEEP_REQUEST_BIT]; // R11
  assign builtinPatternMode = strapTest_q | testPat_q[PATTERN_ENABLE_BIT]; // R14

  // Next control outputs, registered so they come from flip-flops.
  always_comb
  begin
    ctl_d = 8'h00;
    ctl_d[0] = awake && (state_q == PWR_WAIT_VIDEO || state_q == PWR_RUN); // R2
    ctl_d[1] = awake && state_q != PWR_OFF; // R8
    ctl_d[2] = awake && state_q == PWR_RUN; // R3
    ctl_d[3] = awake && state_q == PWR_RUN && coreOk; // R7
    ctl_d[4] = display_mode_reg_q[DISPLAY_BLANK_BIT] || state_q != PWR_RUN || powerOnReset; // R4 R10
  end

  // Control storage.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ctl_q <= 8'h10;
    else
      ctl_q <= ctl_d;
  end

  assign cathodeSupplyEn = ctl_q[0];
  assign arraySupplyEn = ctl_q[1];
  assign videoPathEn = ctl_q[2];
  assign rowColSeqEn = ctl_q[3];
  assign pixelForceBlack = ctl_q[4];
  assign analogBlockEn = {8{awake}} & ~anaPdn_q; // R13
  assign systemBlockEn = {1'b0, {7{awake}} & ~sysPdn_q[6:0]}; // R13

  ////////////////////////////////////////////////////////////////////////////
  // Built-in pattern raster clocked by clk, stepped on oscillator rising edges only.
  logic [7:0] tick_q, tick_d;
  logic [10:0] line_q, line_d;
  logic [3:0] pix_q, pix_d;
  logic [2:0] patSync_q, patSync_d;
  logic patRun;
  logic on;

  assign patRun = builtinPatternMode && awake && state_q == PWR_RUN; // R15

  // Next raster position, syncs and pixel level.
  always_comb
  begin
    tick_d = tick_q;
    line_d = line_q;
    patSync_d = {patRun & syncB_q[5], patSync_q[1:0]}; // R16
    if (!patRun)
    begin
      tick_d = 8'h00;
      line_d = 11'h000;
      patSync_d = 3'b000;
    end
    else if (oscRise)
    begin
      patSync_d[0] = tick_q == 8'h00;
      patSync_d[1] = tick_q == 8'h00 && line_q == 11'h000;
      if (tick_q == 8'(LINE_TICKS - 1)) // R17
      begin
        tick_d = 8'h00;
        line_d = line_q == 11'(FRAME_LINES - 1) ? 11'h000 : line_q + 11'h001;
      end
      else
        tick_d = tick_q + 8'h01;
    end
    else
      patSync_d[1:0] = 2'b00;
    on = 1'b1;
    pix_d = 4'hf; // R18
    case (testPat_q[PATTERN_SEL_LSB +: PATTERN_SEL_W]) // R19
      PAT_GRAY: pix_d = tick_q[5:2];
      PAT_CHECKER: on = tick_q[3] ^ line_q[3];
      PAT_ROWS: on = line_q[0];
      PAT_COLS: on = tick_q[0];
      PAT_HATCH: on = tick_q[3:0] == 4'h0 || line_q[3:0] == 4'h0;
      default: on = 1'b1;
    endcase
    if (!on || !patRun || pixelForceBlack)
      pix_d = 4'h0; // R4
  end

  // Raster storage.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tick_q <= 8'h00;
      line_q <= 11'h000;
      pix_q <= 4'h0;
      patSync_q <= 3'b000;
    end
    else
    begin
      tick_q <= tick_d;
      line_q <= line_d;
      pix_q <= pix_d;
      patSync_q <= patSync_d;
    end
  end

  assign patternHsync = patSync_q[0];
  assign patternVsync = patSync_q[1];
  assign patternSclk = patSync_q[2];
  assign patternPixel = pix_q;

endmodule : dps_display_power_sequencer

//--- tb/dps_supply_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Supply monitors and converter oscillator seen by the sequencer.
module dps_supply_model (
  // Rail commands from the bench.
  input wire logic coreOn,
  input wire logic arrayOn,
  // Monitor levels and oscillator.
  output logic coreSupplyOk,
  output logic arraySupplyOk,
  output logic converterOscClk
);
  // The oscillator runs free at one eighth of the system clock rate, its edges on falling clock edges.
  initial converterOscClk = 1'b0;
  always #160 converterOscClk = ~converterOscClk;
  // Monitors follow the rails after a short settling time.
  assign #15 coreSupplyOk = coreOn;
  assign #15 arraySupplyOk = arrayOn;
endmodule : dps_supply_model

//--- tb/dps_checker.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Port-level checks of the power sequencer.
module dps_checker
  import dps_pkg::*;
#(
  parameter int unsigned CATHODE_DELAY = 100,
  parameter int unsigned VIDEO_DELAY = 50
) (
  // Clock, reset and bus answer.
  input wire logic clk,
  input wire logic rstn,
  input wire logic hreadyout,
  input wire logic hresp,
  // Supplies and pins.
  input wire logic coreSupplyOk,
  input wire logic arraySupplyOk,
  input wire logic addressSelectPin,
  // Controls.
  input wire logic powerOnReset,
  input wire logic cathodeSupplyEn,
  input wire logic arraySupplyEn,
  input wire logic videoPathEn,
  input wire logic rowColSeqEn,
  input wire logic pixelForceBlack,
  input wire logic [6:0] serialSlaveAddr,
  input wire logic builtinPatternMode,
  input wire logic patternHsync,
  input wire logic patternVsync
);
  int unsigned porCnt_q, porCnt_d, cathCnt_q, cathCnt_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Cycles since power-on reset ended and since the cathode supply came on.
  always_comb
  begin
    porCnt_d = powerOnReset ? 0 : porCnt_q + (porCnt_q < 32'hffff);
    cathCnt_d = cathodeSupplyEn ? cathCnt_q + (cathCnt_q < 32'hffff) : 0;
  end
  // Counter registers.
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      porCnt_q <= 0;
      cathCnt_q <= 0;
    end
    else
    begin
      porCnt_q <= porCnt_d;
      cathCnt_q <= cathCnt_d;
    end
  ////////////////////////////////////////////////////////////////////////////////
  AST_POR_RELEASE: assert property ((coreSupplyOk && arraySupplyOk) [*3] |-> !powerOnReset)
    else $error("power-on reset held with both supplies good");
  AST_CORE_LOW_POR: assert property (!coreSupplyOk [*3] |-> powerOnReset)
    else $error("power-on reset missing with core supply low");
  AST_CATH_DELAY: assert property ($rose(cathodeSupplyEn) && $past(arraySupplyEn) |->
    porCnt_q + 1 >= CATHODE_DELAY && porCnt_q <= CATHODE_DELAY + 2)
    else $error("cathode supply enabled at wrong time");
  AST_VIDEO_DELAY: assert property ($rose(videoPathEn) && $past(cathodeSupplyEn) |->
    cathCnt_q + 1 >= VIDEO_DELAY && cathCnt_q <= VIDEO_DELAY + 2)
    else $error("video path enabled at wrong time");
  AST_VIDEO_NEEDS_RAILS: assert property (videoPathEn |-> cathodeSupplyEn && arraySupplyEn)
    else $error("video path on without supplies");
  AST_DROP_STOPS: assert property ($rose(powerOnReset) |->
    ##[1:2] (!rowColSeqEn && !cathodeSupplyEn && !videoPathEn))
    else $error("sequencing not stopped on supply drop");
  AST_ARRAY_LAST: assert property ($fell(cathodeSupplyEn) && arraySupplyEn |->
    arraySupplyEn [*3] ##[1:3] !arraySupplyEn)
    else $error("array supply not turned off after cathode");
  AST_POR_BLACK: assert property (powerOnReset |=> pixelForceBlack)
    else $error("pixels not black during power-on reset");
  AST_SLAVE_ADDR: assert property ($stable(addressSelectPin) [*3] |->
    serialSlaveAddr == {SERIAL_ADDR_HI, addressSelectPin})
    else $error("serial slave address wrong");
  AST_VSYNC_FRAME: assert property (patternVsync |-> builtinPatternMode && patternHsync)
    else $error("vertical sync outside pattern line start");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  // Main scenarios.
  COV_VIDEO: cover property ($rose(videoPathEn));
  COV_DROP: cover property ($fell(arraySupplyEn));
  COV_FRAME: cover property ($rose(patternVsync));
endmodule : dps_checker
bind dps_display_power_sequencer dps_checker #(
  .CATHODE_DELAY(CATHODE_DELAY),
  .VIDEO_DELAY(VIDEO_DELAY)
) i_dps_checker (.clk, .rstn, .hreadyout, .hresp, .coreSupplyOk, .arraySupplyOk,
  .addressSelectPin, .powerOnReset, .cathodeSupplyEn, .arraySupplyEn, .videoPathEn,
  .rowColSeqEn, .pixelForceBlack, .serialSlaveAddr, .builtinPatternMode, .patternHsync,
  .patternVsync);

//--- tb/testbench.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the display power sequencer.
module testbench;
  import dps_pkg::*;
  localparam int CD = 100;
  localparam int VD = 50;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic extResetLowPinN = 1'b1;
  logic selftestPin = 1'b0;
  logic addressSelectPin = 1'b1;
  logic coreOn = 1'b0;
  logic arrayOn = 1'b0;
  logic hreadyout, hresp, coreSupplyOk, arraySupplyOk, converterOscClk, powerOnReset;
  logic cathodeSupplyEn, arraySupplyEn, videoPathEn, rowColSeqEn, pixelForceBlack;
  logic builtinPatternMode, patternHsync, patternVsync, patternSclk;
  logic [31:0] hrdata;
  logic [7:0] analogBlockEn, systemBlockEn;
  logic [6:0] serialSlaveAddr;
  logic [3:0] patternPixel;
  int checks = 0;
  int miscompares = 0;
  int n;
  // Clock at 25 MHz.
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  dps_supply_model i_dps_supply_model (.coreOn, .arrayOn, .coreSupplyOk, .arraySupplyOk,
    .converterOscClk);
  dps_display_power_sequencer #(.CATHODE_DELAY(CD), .VIDEO_DELAY(VD), .LINE_TICKS(8),
    .FRAME_LINES(4)) i_dps_display_power_sequencer (.clk, .rstn, .hsel(1'b1), .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .coreSupplyOk, .arraySupplyOk, .extResetLowPinN, .selftestPin,
    .addressSelectPin, .converterOscClk, .powerOnReset, .cathodeSupplyEn, .arraySupplyEn,
    .videoPathEn, .rowColSeqEn, .pixelForceBlack, .analogBlockEn, .systemBlockEn,
    .serialSlaveAddr, .builtinPatternMode, .patternHsync, .patternVsync, .patternSclk,
    .patternPixel);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Waits a bounded number of edges for a level; running out ends the run.
  task automatic wait_for(ref logic s, input logic v, output int k);
    k = 0;
    while (s !== v && k < 5000)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 5000)
    begin
      miscompares++;
      stop_test();
    end
  endtask : wait_for
  // Waits for ready sampled high at a rising edge; running out ends the run.
  task automatic wait_ready;
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 5000);
    if (hreadyout !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
  endtask : wait_ready
  // One single-word transfer: address phase, then data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, {24'h0, e});
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    repeat (10) @(posedge clk);
    coreOn <= 1'b1;
    arrayOn <= 1'b1;
    rstn <= 1'b1;
    wait_for(powerOnReset, 1'b0, n);
    wait_for(cathodeSupplyEn, 1'b1, n);
    chk(n >= CD - 1 && n <= CD + 2, 1);
    chk(arraySupplyEn, 1);
    wait_for(videoPathEn, 1'b1, n);
    chk(n >= VD - 1 && n <= VD + 2, 1);
    chk(pixelForceBlack, 1);
    rd(DISPLAY_MODE_OFS, DISPLAY_MODE_RST);
    rd(SYSTEM_POWERDOWN_OFS, SYSTEM_POWERDOWN_RST);
    rd(ANALOG_POWERDOWN_OFS, ANALOG_POWERDOWN_RST);
    rd(TEST_PATTERN_OFS, TEST_PATTERN_RST);
    rd(8'h20, 8'h00);
    chk(serialSlaveAddr, {SERIAL_ADDR_HI, 1'b1});
    extResetLowPinN <= 1'b0;
    addressSelectPin <= 1'b0;
    repeat (3) @(posedge clk);
    chk(serialSlaveAddr, {SERIAL_ADDR_HI, 1'b0});
    wr(DISPLAY_MODE_OFS, 8'h00);
    rd(DISPLAY_MODE_OFS, 8'h80);
    extResetLowPinN <= 1'b1;
    repeat (3) @(posedge clk);
    wr(ANALOG_POWERDOWN_OFS, 8'h05);
    wr(SYSTEM_POWERDOWN_OFS, 8'h03);
    wr(DISPLAY_MODE_OFS, 8'h00);
    repeat (3) @(posedge clk);
    chk(pixelForceBlack, 0);
    chk(analogBlockEn, 8'hfa);
    chk(systemBlockEn, 8'h7c);
    wr(SYSTEM_POWERDOWN_OFS, 8'h83);
    repeat (3) @(posedge clk);
    chk({cathodeSupplyEn, videoPathEn, rowColSeqEn, systemBlockEn}, 0);
    rd(ANALOG_POWERDOWN_OFS, 8'h05);
    wr(SYSTEM_POWERDOWN_OFS, 8'h03);
    wait_for(videoPathEn, 1'b1, n);
    rd(DISPLAY_MODE_OFS, 8'h00);
    chk(analogBlockEn, 8'hfa);
    for (int p = 5; p >= 0; p--)
    begin
      wr(TEST_PATTERN_OFS, 8'h80 | p[7:0]);
      rd(TEST_PATTERN_OFS, 8'h80 | p[7:0]);
      chk(builtinPatternMode, 1);
    end
    wait_for(patternVsync, 1'b1, n);
    wait_for(patternVsync, 1'b0, n);
    wait_for(patternVsync, 1'b1, n);
    chk(n >= 253 && n <= 257, 1);
    chk(patternPixel, 4'hf);
    wr(TEST_PATTERN_OFS, {5'h10, PAT_ROWS});
    wait_for(patternVsync, 1'b0, n);
    wait_for(patternVsync, 1'b1, n);
    chk(patternPixel, 4'h0);
    chk({patternHsync, patternSclk}, 2'b11);
    coreOn <= 1'b0;
    wait_for(rowColSeqEn, 1'b0, n);
    chk(n <= 5, 1);
    wait_for(arraySupplyEn, 1'b0, n);
    chk(n >= 3 && n <= 7, 1);
    selftestPin <= 1'b1;
    coreOn <= 1'b1;
    wait_for(powerOnReset, 1'b0, n);
    rd(DISPLAY_MODE_OFS, DISPLAY_MODE_RST);
    chk(builtinPatternMode, 1);
    wait_for(cathodeSupplyEn, 1'b1, n);
    chk(n >= CD - 1 && n <= CD + 2, 1);
    stop_test();
  end
endmodule : testbench
